// >>> hdl/eac_nv_access.sv
// Nonvolatile byte access unit on the core's register space
`timescale 1ns/1ps

// How it works
// - A 512-byte nonvolatile array; every access moves exactly one byte.
// - Address, data and control registers sit in the core's I/O space.
// - Writes time themselves; a busy bit shows when the next may start.
// - Triggering a read stalls the core for four cycles.
// - Starting a write stalls the core for two cycles.
// - A write starts only after the master enable unlock step.
// - A write already running completes even if reset arrives.
// - Registers 0x00-0x1F accept bit set, bit clear and bit test.
// - I/O ops use 0x00-0x3F; data-space ops see them at plus 0x20.
// - Extended area 0x60-0xFF is only reached by data-space loads/stores.
// - Bit set and clear change only the named bit.
// - Address bits 15..9 read zero and ignore writes.
// - Address field is bits 8..0, linear, undefined after reset.
// - Data register feeds write data and receives read data.
// - Control bits 7..6 read as zero.
// - Master enable lasts four cycles; write strobe must follow inside them.
// - Hardware clears the write strobe when the write time ends.
// - Mode field picks action and time; frozen while a write runs.
// - Read loads data at once; busy blocks reads and address changes.
module eac_nv_access #(
  parameter int unsigned WR_FULL_CYC = eac_pkg::WR_FULL_CYC,
  parameter int unsigned WR_HALF_CYC = eac_pkg::WR_HALF_CYC
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Register access from the core
  input wire logic req_valid_i,
  input wire logic [2:0] req_op_i,
  input wire logic [7:0] req_addr_i,
  input wire logic [2:0] req_bit_i,
  input wire logic [7:0] req_wdata_i,
  // Answers to the core
  output logic [7:0] rdata_o,
  output logic skip_o,
  output logic stall_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic stall_q;
  logic acc_go;
  logic acc_ok;
  logic acc_rd;
  logic acc_wr;
  logic acc_test;
  logic [5:0] acc_idx;
  logic [7:0] acc_mask;
  logic [7:0] acc_wdat;
  logic sel_ctrl;
  logic sel_data;
  logic sel_addrl;
  logic sel_addrh;
  logic [7:0] rd_val;
  logic [7:0] ctrl_val;
  logic [8:0] nv_addr_reg_q;
  logic [8:0] nv_addr_reg_d;
  logic [7:0] nv_data_reg_q;
  logic [7:0] nv_data_reg_d;
  logic [1:0] prog_mode_q;
  logic [1:0] prog_mode_d;
  logic [7:0] wr_byte_q;
  logic [7:0] wr_byte_d;
  eac_pkg::eac_wr_state_e wr_state_q;
  eac_pkg::eac_wr_state_e wr_state_d;
  logic [19:0] wr_tmr_q;
  logic [19:0] wr_tmr_d;
  logic master_write_enable;
  logic write_strobe;
  logic mwe_set;
  logic mwe_clear;
  logic ws_start;
  logic read_strobe;
  logic prog_go;
  logic [7:0] nv_rd_byte;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic skip_q;
  logic skip_d;

  ////////////////////////////////////////////////////////////////////////////
  // Request decode
  // Requests are refused while the core is stalled or held in reset
  assign acc_go = req_valid_i && !stall_q && !rst_i;

  // Map each op onto an I/O index, a bit mask and the write value
  always_comb
  begin
    acc_ok = 1'b0;
    acc_rd = 1'b0;
    acc_wr = 1'b0;
    acc_test = 1'b0;
    acc_idx = req_addr_i[5:0];
    acc_mask = eac_pkg::MASK_NONE;
    acc_wdat = req_wdata_i;
    case (req_op_i)
      eac_pkg::OP_IN, eac_pkg::OP_OUT:
      begin
        acc_ok = (req_addr_i < eac_pkg::IO_SPAN);
        acc_rd = (req_op_i == eac_pkg::OP_IN);
        acc_wr = (req_op_i == eac_pkg::OP_OUT);
        acc_mask = eac_pkg::MASK_ALL;
      end
      eac_pkg::OP_LD, eac_pkg::OP_ST:
      begin
        // Extended locations hold nothing of ours and answer zero
        acc_ok = (req_addr_i >= eac_pkg::DS_IO_BASE) &&
                 (req_addr_i < eac_pkg::DS_EXT_BASE);
        acc_idx = 6'(req_addr_i - eac_pkg::DS_IO_BASE);
        acc_rd = (req_op_i == eac_pkg::OP_LD);
        acc_wr = (req_op_i == eac_pkg::OP_ST);
        acc_mask = eac_pkg::MASK_ALL;
      end
      eac_pkg::OP_SBI, eac_pkg::OP_CBI:
      begin
        acc_ok = (req_addr_i[7:0] <= {2'h0, eac_pkg::IO_BIT_LIMIT});
        acc_wr = 1'b1;
        acc_mask = 8'h01 << req_bit_i;
        acc_wdat = (req_op_i == eac_pkg::OP_SBI) ? eac_pkg::MASK_ALL :
                   eac_pkg::MASK_NONE;
      end
      eac_pkg::OP_SKIP_IF_BIT_SET_INSTRUCTION, eac_pkg::OP_SBIC:
      begin
        acc_ok = (req_addr_i[7:0] <= {2'h0, eac_pkg::IO_BIT_LIMIT});
        acc_test = 1'b1;
      end
      default:
      begin
        acc_ok = 1'b0;
      end
    endcase
  end

  // Register selects
  assign sel_ctrl = acc_go && acc_ok && (acc_idx == eac_pkg::IO_CTRL_ADDR);
  assign sel_data = acc_go && acc_ok && (acc_idx == eac_pkg::IO_DATA_ADDR);
  assign sel_addrl = acc_go && acc_ok && (acc_idx == eac_pkg::IO_ADDRL_ADDR);
  assign sel_addrh = acc_go && acc_ok && (acc_idx == eac_pkg::IO_ADDRH_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // Control register view and read mux
  assign write_strobe = (wr_state_q == eac_pkg::WR_BUSY);

  // Reserved bits and the read strobe always read as zero
  always_comb
  begin
    ctrl_val = 8'h00;
    ctrl_val[eac_pkg::CTRL_PM_HI:eac_pkg::CTRL_PM_LO] = prog_mode_q;
    ctrl_val[eac_pkg::CTRL_MWE_BIT] = master_write_enable;
    ctrl_val[eac_pkg::CTRL_WS_BIT] = write_strobe;
  end

  // Unmapped and reserved locations read as zero
  always_comb
  begin
    rd_val = 8'h00;
    if (acc_ok)
    begin
      case (acc_idx)
        eac_pkg::IO_CTRL_ADDR: rd_val = ctrl_val;
        eac_pkg::IO_DATA_ADDR: rd_val = nv_data_reg_q;
        eac_pkg::IO_ADDRL_ADDR: rd_val = nv_addr_reg_q[7:0];
        eac_pkg::IO_ADDRH_ADDR: rd_val = {7'h00, nv_addr_reg_q[8]};
        default: rd_val = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control bit events
  // Master enable written one arms the four-cycle window
  assign mwe_set = sel_ctrl && acc_wr && acc_mask[eac_pkg::CTRL_MWE_BIT] &&
                   acc_wdat[eac_pkg::CTRL_MWE_BIT];
  assign mwe_clear = sel_ctrl && acc_wr && acc_mask[eac_pkg::CTRL_MWE_BIT] &&
                     !acc_wdat[eac_pkg::CTRL_MWE_BIT];

  // Strobe without a live unlock window, or with the reserved mode, is dropped
  assign ws_start = sel_ctrl && acc_wr && acc_mask[eac_pkg::CTRL_WS_BIT] &&
                    acc_wdat[eac_pkg::CTRL_WS_BIT] && master_write_enable &&
                    (wr_state_q == eac_pkg::WR_IDLE) &&
                    (prog_mode_q != eac_pkg::PM_RESERVED);

  // Reads are blocked while a write runs
  assign read_strobe = sel_ctrl && acc_wr && acc_mask[eac_pkg::CTRL_RE_BIT] &&
                       acc_wdat[eac_pkg::CTRL_RE_BIT] &&
                       (wr_state_q == eac_pkg::WR_IDLE);

  // Four-cycle unlock window; cleared by hardware at its end
  eac_cycle_timer u_mwe_timer (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .load_i(mwe_set),
    .load_val_i(eac_pkg::MWE_HOLD_CYC),
    .clear_i(mwe_clear),
    .busy_o(master_write_enable)
  );

  // Core stall after a read trigger or a write start
  eac_cycle_timer u_stall_timer (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .load_i(read_strobe || ws_start),
    .load_val_i(read_strobe ? eac_pkg::STALL_READ_CYC :
                eac_pkg::STALL_WRITE_CYC),
    .clear_i(1'b0),
    .busy_o(stall_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address, data and mode registers
  always_comb
  begin
    nv_addr_reg_d = nv_addr_reg_q;
    nv_data_reg_d = nv_data_reg_q;
    prog_mode_d = prog_mode_q;
    // Address frozen during a write so the running byte keeps its target
    if (sel_addrl && acc_wr && !write_strobe)
    begin
      nv_addr_reg_d[7:0] = (nv_addr_reg_q[7:0] & ~acc_mask) |
                           (acc_wdat & acc_mask);
    end
    if (sel_addrh && acc_wr && !write_strobe &&
        acc_mask[eac_pkg::ADDRH_TOP_BIT])
    begin
      nv_addr_reg_d[8] = acc_wdat[eac_pkg::ADDRH_TOP_BIT];
    end
    if (sel_data && acc_wr)
    begin
      nv_data_reg_d = (nv_data_reg_q & ~acc_mask) | (acc_wdat & acc_mask);
    end
    if (read_strobe)
    begin
      nv_data_reg_d = nv_rd_byte;
    end
    if (sel_ctrl && acc_wr && !write_strobe)
    begin
      if (acc_mask[eac_pkg::CTRL_PM_LO])
      begin
        prog_mode_d[0] = acc_wdat[eac_pkg::CTRL_PM_LO];
      end
      if (acc_mask[eac_pkg::CTRL_PM_HI])
      begin
        prog_mode_d[1] = acc_wdat[eac_pkg::CTRL_PM_HI];
      end
    end
  end

  // Address has no reset value; mode resets only when no write runs
  always_ff @(posedge core_clk_i)
  begin
    nv_addr_reg_q <= nv_addr_reg_d;
    if (rst_i)
    begin
      nv_data_reg_q <= eac_pkg::DATA_RESET;
    end
    else
    begin
      nv_data_reg_q <= nv_data_reg_d;
    end
    if (rst_i && !write_strobe)
    begin
      prog_mode_q <= eac_pkg::PM_ERASE_WRITE;
    end
    else
    begin
      prog_mode_q <= prog_mode_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Self-timed write sequencer
  // Data is latched at start so late data writes cannot corrupt the byte
  always_comb
  begin
    wr_state_d = wr_state_q;
    wr_tmr_d = wr_tmr_q;
    wr_byte_d = wr_byte_q;
    prog_go = 1'b0;
    case (wr_state_q)
      eac_pkg::WR_IDLE:
      begin
        if (ws_start)
        begin
          wr_state_d = eac_pkg::WR_BUSY;
          wr_byte_d = nv_data_reg_q;
          wr_tmr_d = (prog_mode_q == eac_pkg::PM_ERASE_WRITE) ?
                     20'(WR_FULL_CYC - 1) : 20'(WR_HALF_CYC - 1);
        end
      end
      eac_pkg::WR_BUSY:
      begin
        if (wr_tmr_q == 20'h00000)
        begin
          prog_go = 1'b1;
          wr_state_d = eac_pkg::WR_IDLE;
        end
        else
        begin
          wr_tmr_d = wr_tmr_q - 20'h00001;
        end
      end
      default:
      begin
        wr_state_d = eac_pkg::WR_IDLE;
      end
    endcase
  end

  // Reset leaves a running write alone so the byte is not lost
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i && (wr_state_q == eac_pkg::WR_IDLE))
    begin
      wr_state_q <= eac_pkg::WR_IDLE;
      wr_tmr_q <= 20'h00000;
      wr_byte_q <= eac_pkg::DATA_RESET;
    end
    else
    begin
      wr_state_q <= wr_state_d;
      wr_tmr_q <= wr_tmr_d;
      wr_byte_q <= wr_byte_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cell array
  eac_nv_array u_array (
    .core_clk_i(core_clk_i),
    .rd_addr_i(nv_addr_reg_q),
    .rd_data_o(nv_rd_byte),
    .prog_i(prog_go),
    .prog_addr_i(nv_addr_reg_q),
    .prog_data_i(wr_byte_q),
    .prog_mode_i(prog_mode_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Answers to the core
  // Read data holds until the next read; skip is a one-cycle pulse
  always_comb
  begin
    rdata_d = rdata_q;
    skip_d = 1'b0;
    if (acc_go && acc_rd)
    begin
      rdata_d = rd_val;
    end
    if (acc_go && acc_test && acc_ok)
    begin
      skip_d = rd_val[req_bit_i] ==
               (req_op_i == eac_pkg::OP_SKIP_IF_BIT_SET_INSTRUCTION);
    end
  end

  // Registers
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      rdata_q <= 8'h00;
      skip_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      skip_q <= skip_d;
    end
  end

  assign rdata_o = rdata_q;
  assign skip_o = skip_q;
  assign stall_o = stall_q;

endmodule // eac_nv_access

// >>> hdl/eac_pkg.sv
// Shared constants and types for the nonvolatile byte access unit
package eac_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and widths
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NV_ADDR_W = 9;
  localparam int unsigned NV_DEPTH = 512;
  localparam int unsigned IO_ADDR_W = 6;
  localparam int unsigned WR_CNT_W = 20;
  localparam int unsigned STALL_W = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Address map of the core's register space
  localparam logic [5:0] IO_CTRL_ADDR = 6'h1f;
  localparam logic [5:0] IO_DATA_ADDR = 6'h20;
  localparam logic [5:0] IO_ADDRL_ADDR = 6'h21;
  localparam logic [5:0] IO_ADDRH_ADDR = 6'h22;
  localparam logic [5:0] IO_BIT_LIMIT = 6'h1f;
  localparam logic [7:0] IO_SPAN = 8'h40;
  localparam logic [7:0] DS_IO_BASE = 8'h20;
  localparam logic [7:0] DS_EXT_BASE = 8'h60;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields and the address high bit
  localparam int unsigned CTRL_RE_BIT = 0;
  localparam int unsigned CTRL_WS_BIT = 1;
  localparam int unsigned CTRL_MWE_BIT = 2;
  localparam int unsigned CTRL_PM_LO = 4;
  localparam int unsigned CTRL_PM_HI = 5;
  localparam int unsigned ADDRH_TOP_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and fixed byte patterns
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] MASK_ALL = 8'hff;
  localparam logic [7:0] MASK_NONE = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle counts
  localparam logic [2:0] STALL_READ_CYC = 3'h4;
  localparam logic [2:0] STALL_WRITE_CYC = 3'h2;
  localparam logic [2:0] MWE_HOLD_CYC = 3'h4;
  localparam int unsigned WR_FULL_TIME_NS = 3400000;
  localparam int unsigned WR_HALF_TIME_NS = 1800000;
  localparam int unsigned WR_FULL_CYC = (WR_FULL_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WR_HALF_CYC = (WR_HALF_TIME_NS * CLK_MHZ + 999) / 1000;

  ////////////////////////////////////////////////////////////////////////////
  // Enumerations
  typedef enum logic [1:0] {
    PM_ERASE_WRITE = 2'h0,
    PM_ERASE_ONLY = 2'h1,
    PM_WRITE_ONLY = 2'h2,
    PM_RESERVED = 2'h3
  } eac_pm_e;

  typedef enum logic [2:0] {
    OP_IN = 3'h0,
    OP_OUT = 3'h1,
    OP_LD = 3'h2,
    OP_ST = 3'h3,
    OP_SBI = 3'h4,
    OP_CBI = 3'h5,
    OP_SKIP_IF_BIT_SET_INSTRUCTION = 3'h6,
    OP_SBIC = 3'h7
  } eac_op_e;

  typedef enum logic {
    WR_IDLE = 1'b0,
    WR_BUSY = 1'b1
  } eac_wr_state_e;

endpackage

// >>> hdl/eac_cycle_timer.sv
// Small down counter that holds a busy flag for a loaded number of cycles
`timescale 1ns/1ps
module eac_cycle_timer (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Control
  input wire logic load_i,
  input wire logic [2:0] load_val_i,
  input wire logic clear_i,
  // Status
  output logic busy_o
);

  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic busy_q;
  logic busy_d;

  // Busy stays high for exactly load_val cycles after the load cycle
  always_comb
  begin
    cnt_d = cnt_q;
    if (clear_i)
    begin
      cnt_d = 3'h0;
    end
    else if (load_i)
    begin
      cnt_d = load_val_i;
    end
    else if (cnt_q != 3'h0)
    begin
      cnt_d = cnt_q - 3'h1;
    end
    busy_d = (cnt_d != 3'h0);
  end

  // Registers
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= 3'h0;
      busy_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
    end
  end

  assign busy_o = busy_q;

endmodule // eac_cycle_timer

// >>> hdl/eac_nv_array.sv
// Byte array that models the nonvolatile cells and the program actions
`timescale 1ns/1ps
module eac_nv_array (
  // Clock
  input wire logic core_clk_i,
  // Read port
  input wire logic [8:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  // Program port
  input wire logic prog_i,
  input wire logic [8:0] prog_addr_i,
  input wire logic [7:0] prog_data_i,
  input wire logic [1:0] prog_mode_i
);

  logic [7:0] cells_q [eac_pkg::NV_DEPTH];
  logic [7:0] new_byte;

  // Erase drives all ones; a plain write can only clear bits
  always_comb
  begin
    case (prog_mode_i)
      eac_pkg::PM_ERASE_WRITE: new_byte = prog_data_i;
      eac_pkg::PM_ERASE_ONLY: new_byte = eac_pkg::ERASED_BYTE;
      eac_pkg::PM_WRITE_ONLY: new_byte = cells_q[prog_addr_i] & prog_data_i;
      default: new_byte = cells_q[prog_addr_i];
    endcase
  end

  // Cells are never reset, they keep contents across resets
  always_ff @(posedge core_clk_i)
  begin
    if (prog_i)
    begin
      cells_q[prog_addr_i] <= new_byte;
    end
  end

  assign rd_data_o = cells_q[rd_addr_i];

endmodule // eac_nv_array

// >>> bench/eac_nv_access_properties.sv
// Port-level assertions for the nonvolatile access unit
`timescale 1ns/1ps
module eac_nv_access_chk #(
  parameter int unsigned WR_FULL_CYC = 20,
  parameter int unsigned WR_HALF_CYC = 10
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Requests from the core
  input wire logic req_valid_i,
  input wire logic [2:0] req_op_i,
  input wire logic [7:0] req_addr_i,
  input wire logic [2:0] req_bit_i,
  input wire logic [7:0] req_wdata_i,
  // Answers to the core
  input wire logic [7:0] rdata_o,
  input wire logic skip_o,
  input wire logic stall_o
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////
  // Decode of the request taken at this edge
  logic tk;
  logic ctl_wr;
  logic sbi_c;
  logic re_req;
  logic ws_req;
  logic rd_op;
  logic tst;
  logic [7:0] ds;
  assign tk = req_valid_i && !stall_o && !rst_i;
  assign ctl_wr = req_op_i == eac_pkg::OP_OUT && req_addr_i == 8'h1f
               || req_op_i == eac_pkg::OP_ST && req_addr_i == 8'h3f;
  assign sbi_c = req_op_i == eac_pkg::OP_SBI && req_addr_i == 8'h1f;
  assign re_req = tk && (ctl_wr && req_wdata_i[0] || sbi_c && req_bit_i == 3'h0);
  assign ws_req = tk && (ctl_wr && req_wdata_i[1] || sbi_c && req_bit_i == 3'h1);
  assign rd_op = tk && (req_op_i == eac_pkg::OP_IN || req_op_i == eac_pkg::OP_LD);
  assign tst = tk && (req_op_i == eac_pkg::OP_SKIP_IF_BIT_SET_INSTRUCTION || req_op_i == eac_pkg::OP_SBIC);
  // Data-space form, so I/O and load reads share one decode
  assign ds = req_addr_i + ((req_op_i == eac_pkg::OP_IN) ? 8'h20 : 8'h00);

  ////////////////////////////////////////
  // Stall and answer timing
  stall_src_a: assert property ($rose(stall_o) |-> $past(re_req || ws_req))
    else $error("stall without a strobe");
  rd_stall_a: assert property ($rose(stall_o) && $past(re_req && !ws_req) |->
    stall_o [*4] ##1 !stall_o) else $error("read stall length wrong");
  wr_stall_a: assert property ($rose(stall_o) && $past(ws_req && !re_req) |->
    stall_o [*2] ##1 !stall_o) else $error("write stall length wrong");
  skip_src_a: assert property (skip_o |-> $past(tst && req_addr_i <= 8'h1f))
    else $error("skip without a bit test");
  bit_range_a: assert property (tst && req_addr_i > 8'h1f |=> !skip_o)
    else $error("bit test above bit range");
  ctl_bits_a: assert property (tst && req_addr_i == 8'h1f && (req_bit_i == 3'h0
    || req_bit_i == 3'h3 || req_bit_i[2:1] == 2'h3)
    |=> skip_o == $past(req_op_i == eac_pkg::OP_SBIC)) else $error("zero bit tested wrong");
  ctl_rsvd_a: assert property (rd_op && ds == 8'h3f |=>
    rdata_o[7:6] == 2'h0 && !rdata_o[3] && !rdata_o[0]) else $error("control zero bits set");
  addr_rsvd_a: assert property (rd_op && ds == 8'h42 |=> rdata_o[7:1] == 7'h00)
    else $error("address high upper bits set");
  io_range_a: assert property (rd_op && (ds < 8'h20 || ds >= 8'h60) |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  rd_hold_a: assert property (!$past(rd_op) |-> $stable(rdata_o))
    else $error("read data moved without a read");

  // Main scenarios
  cover property (re_req ##1 stall_o);
  cover property (ws_req ##1 stall_o);
  cover property (skip_o);
endmodule // eac_nv_access_chk

bind eac_nv_access eac_nv_access_chk #(
  .WR_FULL_CYC(WR_FULL_CYC),
  .WR_HALF_CYC(WR_HALF_CYC)
) u_chk (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_op_i(req_op_i),
  .req_addr_i(req_addr_i), .req_bit_i(req_bit_i), .req_wdata_i(req_wdata_i),
  .rdata_o(rdata_o), .skip_o(skip_o), .stall_o(stall_o)
);

// >>> bench/eac_core_model.sv
// Behavioural processor core issuing register requests
`timescale 1ns/1ps
module eac_core_model (
  // Clock
  input wire logic core_clk_i,
  // Requests to the unit
  output logic req_valid_o,
  output logic [2:0] req_op_o,
  output logic [7:0] req_addr_o,
  output logic [2:0] req_bit_o,
  output logic [7:0] req_wdata_o,
  // Answers from the unit
  input wire logic [7:0] rdata_i,
  input wire logic skip_i,
  input wire logic stall_i
);
  // Idle bus at time zero
  initial
  begin
    req_valid_o = 1'b0;
    req_op_o = 3'h0;
    req_addr_o = 8'h00;
    req_bit_o = 3'h0;
    req_wdata_o = 8'h00;
  end

  ////////////////////////////////////////
  // One access; n counts the stall cycles that follow
  task automatic acc(input logic [2:0] o, input logic [7:0] a, input logic [2:0] b,
                     input logic [7:0] d, output logic [7:0] r, output logic s,
                     output int n);
    @(posedge core_clk_i);
    req_valid_o <= 1'b1;
    req_op_o <= o;
    req_addr_o <= a;
    req_bit_o <= b;
    req_wdata_o <= d;
    // Held until an edge that finds the unit unstalled
    @(negedge core_clk_i);
    while (stall_i !== 1'b0)
      @(negedge core_clk_i);
    @(posedge core_clk_i);
    req_valid_o <= 1'b0;
    req_addr_o <= ~a;
    req_wdata_o <= ~d;
    // Answers stand from the taking edge; skip lasts that one cycle only
    @(negedge core_clk_i);
    r = rdata_i;
    s = skip_i;
    n = 0;
    while (stall_i === 1'b1 && n < 9)
    begin
      n++;
      @(negedge core_clk_i);
    end
  endtask

  // Address first; top bit sent alone so reserved bits stay zero
  task automatic set_addr(input logic [8:0] a);
    logic [7:0] r;
    logic s;
    int k;
    acc(eac_pkg::OP_OUT, 8'h22, 3'h0, {7'h00, a[8]}, r, s, k);
    acc(eac_pkg::OP_OUT, 8'h21, 3'h0, a[7:0], r, s, k);
  endtask

  // Unlocked write: master enable, then strobe straight after
  task automatic nv_write(input logic [8:0] a, input logic [7:0] d, input logic [1:0] m,
                          output int n);
    logic [7:0] r;
    logic s;
    set_addr(a);
    acc(eac_pkg::OP_OUT, 8'h20, 3'h0, d, r, s, n);
    acc(eac_pkg::OP_OUT, 8'h1f, 3'h0, {2'h0, m, 4'h0}, r, s, n);
    acc(eac_pkg::OP_OUT, 8'h1f, 3'h0, {2'h0, m, 4'h4}, r, s, n);
    acc(eac_pkg::OP_SBI, 8'h1f, 3'h1, 8'h00, r, s, n);
  endtask

  // Read strobe, then fetch the data register
  task automatic nv_read(input logic [8:0] a, output logic [7:0] r, output int n);
    logic s;
    int k;
    set_addr(a);
    acc(eac_pkg::OP_OUT, 8'h1f, 3'h0, 8'h01, r, s, n);
    acc(eac_pkg::OP_IN, 8'h20, 3'h0, 8'h00, r, s, k);
  endtask
endmodule // eac_core_model

// >>> bench/eac_nv_access_tb.sv
// Self-checking bench for the nonvolatile access unit
`timescale 1ns/1ps
module eac_nv_access_tb;
  // Short write times keep the run brief
  localparam int WF = 20;
  localparam int WH = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic vld;
  logic [2:0] op;
  logic [2:0] bn;
  logic [7:0] adr;
  logic [7:0] wd;
  logic [7:0] rdata;
  logic skip;
  logic stall;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [7:0] v;
  logic sk;
  int n;
  int c;
  // Mode table: data, mode, stall, busy time, cell afterwards
  logic [7:0] tw [5] = '{8'h3c, 8'h00, 8'h0f, 8'hf3, 8'h55};
  logic [1:0] tm [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3};
  int ts [5] = '{2, 2, 2, 2, 0};
  int tt [5] = '{WF, WH, WH, WH, 0};
  logic [7:0] tc [5] = '{8'h3c, 8'hff, 8'h0f, 8'h03, 8'h03};

  always #2 clk = ~clk;

  ////////////////////////////////////////
  // Unit and core model
  eac_nv_access #(.WR_FULL_CYC(WF), .WR_HALF_CYC(WH)) uut (
    .core_clk_i(clk), .rst_i(rst), .req_valid_i(vld), .req_op_i(op), .req_addr_i(adr),
    .req_bit_i(bn), .req_wdata_i(wd), .rdata_o(rdata), .skip_o(skip), .stall_o(stall)
  );
  eac_core_model core (
    .core_clk_i(clk), .req_valid_o(vld), .req_op_o(op), .req_addr_o(adr), .req_bit_o(bn),
    .req_wdata_o(wd), .rdata_i(rdata), .skip_i(skip), .stall_i(stall)
  );

  ////////////////////////////////////////
  // Compare, verdict and access helpers
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("Error at %0t ns: saw %h expected %h", $time, s, e);
    end
  endtask

  task automatic wrap_up();
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic go(input logic [2:0] o, input logic [7:0] a, input logic [2:0] b,
                    input logic [7:0] d);
    core.acc(o, a, b, d, v, sk, n);
  endtask

  // Polls the busy bit; c is the time it took
  task automatic idle();
    int t0;
    t0 = cyc;
    go(eac_pkg::OP_IN, 8'h1f, 3'h0, 8'h00);
    while (v[1] !== 1'b0 && cyc - t0 < 400)
      go(eac_pkg::OP_IN, 8'h1f, 3'h0, 8'h00);
    c = cyc - t0;
  endtask

  // Hang guard, well above the expected run
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      bad_count++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // Every program mode, the refused one last
    for (int i = 0; i < 5; i++)
    begin
      core.nv_write(9'h105, tw[i], tm[i], n);
      chk(8'(n), 8'(ts[i]));
      idle();
      chk(8'(c + 3 >= tt[i] && c <= tt[i] + 4), 8'h01);
      core.nv_read(9'h105, v, n);
      chk(8'(n), 8'h04);
      chk(v, tc[i]);
    end
    // Master enable lapses, then the strobe is refused
    go(eac_pkg::OP_OUT, 8'h1f, 3'h0, 8'h00);
    go(eac_pkg::OP_SBI, 8'h1f, 3'h2, 8'h00);
    go(eac_pkg::OP_IN, 8'h1f, 3'h0, 8'h00);
    chk(v, 8'h04);
    repeat (6) @(posedge clk);
    go(eac_pkg::OP_IN, 8'h1f, 3'h0, 8'h00);
    chk(v, 8'h00);
    go(eac_pkg::OP_SBI, 8'h1f, 3'h1, 8'h00);
    chk(8'(n), 8'h00);
    // Address, mode and read strobe frozen while busy
    core.nv_write(9'h0aa, 8'h5a, 2'h0, n);
    go(eac_pkg::OP_OUT, 8'h21, 3'h0, 8'h11);
    go(eac_pkg::OP_OUT, 8'h1f, 3'h0, 8'h22);
    go(eac_pkg::OP_SBI, 8'h1f, 3'h0, 8'h00);
    chk(8'(n), 8'h00);
    go(eac_pkg::OP_IN, 8'h21, 3'h0, 8'h00);
    chk(v, 8'haa);
    go(eac_pkg::OP_IN, 8'h1f, 3'h0, 8'h00);
    chk(v, 8'h02);
    idle();
    chk(v, 8'h00);
    core.nv_read(9'h0aa, v, n);
    chk(v, 8'h5a);
    // Reset in mid write lets the write finish
    core.nv_write(9'h0ab, 8'hc3, 2'h0, n);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    go(eac_pkg::OP_IN, 8'h1f, 3'h0, 8'h00);
    chk(v, 8'h02);
    idle();
    core.nv_read(9'h0ab, v, n);
    chk(v, 8'hc3);
    // Bit set, clear and test on one bit only
    go(eac_pkg::OP_OUT, 8'h1f, 3'h0, 8'h20);
    go(eac_pkg::OP_SBI, 8'h1f, 3'h4, 8'h00);
    go(eac_pkg::OP_CBI, 8'h1f, 3'h5, 8'h00);
    go(eac_pkg::OP_IN, 8'h1f, 3'h0, 8'h00);
    chk(v, 8'h10);
    go(eac_pkg::OP_SKIP_IF_BIT_SET_INSTRUCTION, 8'h1f, 3'h4, 8'h00);
    chk(8'(sk), 8'h01);
    go(eac_pkg::OP_SBIC, 8'h1f, 3'h7, 8'h00);
    chk(8'(sk), 8'h01);
    go(eac_pkg::OP_OUT, 8'h20, 3'h0, 8'h54);
    go(eac_pkg::OP_SBI, 8'h20, 3'h0, 8'h00);
    go(eac_pkg::OP_SKIP_IF_BIT_SET_INSTRUCTION, 8'h20, 3'h2, 8'h00);
    chk(8'(sk), 8'h00);
    go(eac_pkg::OP_IN, 8'h20, 3'h0, 8'h00);
    chk(v, 8'h54);
    // Address spaces and reserved address bits
    go(eac_pkg::OP_OUT, 8'h22, 3'h0, 8'hff);
    go(eac_pkg::OP_ST, 8'h41, 3'h0, 8'h77);
    go(eac_pkg::OP_LD, 8'h41, 3'h0, 8'h00);
    chk(v, 8'h77);
    go(eac_pkg::OP_LD, 8'h60, 3'h0, 8'h00);
    chk(v, 8'h00);
    go(eac_pkg::OP_LD, 8'h42, 3'h0, 8'h00);
    chk(v, 8'h01);
    go(eac_pkg::OP_IN, 8'h40, 3'h0, 8'h00);
    chk(v, 8'h00);
    wrap_up();
  end
endmodule // eac_nv_access_tb
